// [core/ea_map.svh]
`ifndef EA_MAP_SVH
`define EA_MAP_SVH
// ==========================================================
// word layout, vector bit 17 holds word bit 0, the msb
// ==========================================================
`define EA_WORD_W 18
`define EA_OPCODE_HI 17
`define EA_OPCODE_LO 14
`define EA_MODE_HI 13
`define EA_MODE_LO 12
`define EA_OPERAND_HI 11
`define EA_OPERAND_LO 0
`define EA_PAGE_HI 17
`define EA_PAGE_LO 12
`define EA_BLOCK_HI 17
`define EA_BLOCK_LO 15
`define EA_PTR_HI 14
`define EA_PTR_LO 0
`define EA_JMP_IDX_HI 16
`define EA_STEP_HI 7
`define EA_STEP_W 8
// ==========================================================
// auto-increment window in the first page
// ==========================================================
`define EA_AUTOINC_TAG_HI 17
`define EA_AUTOINC_TAG_LO 3
`define EA_AUTOINC_TAG 15'h0001
// ==========================================================
// reset values
// ==========================================================
`define EA_IP_RESET 18'h00000
`define EA_XR_RESET 18'h00000
`define EA_LR_RESET 18'h00000
`endif

// [core/ea_pkg.sv]
package ea_pkg;
    typedef enum logic [1:0] {
        MODE_DIRECT = 2'h0,
        MODE_INDEXED = 2'h1,
        MODE_INDIRECT = 2'h2,
        MODE_IND_INDEXED = 2'h3
    } addr_mode_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_DECODE, ST_PTR, ST_INCWR, ST_DONE
    } ea_state_e;
endpackage

// [core/page_counter.sv]
`timescale 1ns/100ps
`default_nettype none
// counts only the low bits, page bits pass through
module page_counter #(
    parameter int WORD_W = 18,
    parameter int CNT_W = 12
) (
    input wire logic [WORD_W-1:0] value_i,
    output logic [WORD_W-1:0] next_o
);
    logic [CNT_W-1:0] low;
    assign low = value_i[CNT_W-1:0] + {{(CNT_W-1){1'b0}}, 1'b1};
    assign next_o = {value_i[WORD_W-1:CNT_W], low};
endmodule // page_counter
`default_nettype wire

// [core/ea_adder.sv]
`timescale 1ns/100ps
`default_nettype none
// address adder, carry out of the top bit dropped
module ea_adder #(
    parameter int WORD_W = 18
) (
    input wire logic [WORD_W-1:0] a_i,
    input wire logic [WORD_W-1:0] b_i,
    output logic [WORD_W-1:0] sum_o
);
    logic [WORD_W:0] full;
    assign full = {1'b0, a_i} + {1'b0, b_i};
    assign sum_o = full[WORD_W-1:0];
endmodule // ea_adder
`default_nettype wire

// [core/effective_address_unit.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ea_map.svh"
// Behaviour
// - memory words are 18 bits; only words fetched via pointer are instructions
// - 18-bit instruction pointer incremented at start of every instruction
// - increment wraps within 12 low bits; page, bank, block bits untouched
// - address bits 3-4 pick bank, bit 5 page, rest word in page
// - bit 0 is most significant, bit 17 least significant
// - opcode is bits 0-3; three codes are not memory references
// - operand field is bits 6-17, twelve bits, one page
// - mode 00 direct, 01 indexed, 10 indirect, 11 indirect then indexed
// - direct address is pointer page bits joined to operand field
// - indexed address is page address plus signed 18-bit index
// - indexing costs no cycle beyond the direct case
// - indirect reads pointer word, joins block bits, second memory cycle
// - one indirection level; low 15 pointer bits form the address
// - top three pointer bits ignored for address forming
// - mode 11 resolves pointer first, then adds index
// - 18-bit limit register bounds index in loops
// - index-add-skip adds signed low eight instruction bits to index
// - skip next instruction when index exceeds limit
// - indirect through locations 10-17 octal increments pointer first
// - direct use of those locations is ordinary memory
// - indirect jump loads 15 bits, indexed jump loads 17 bits
module effective_address_unit #(
    parameter logic [3:0] JMP_OP = 4'hD,
    parameter logic [3:0] IDX_SKIP_OP = 4'hE,
    parameter logic [3:0] NONMEM_OP0 = 4'hC,
    parameter logic [3:0] NONMEM_OP1 = 4'hE,
    parameter logic [3:0] NONMEM_OP2 = 4'hF
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic ip_load_i,
    input wire logic [17:0] ip_data_i,
    input wire logic xr_load_i,
    input wire logic [17:0] xr_data_i,
    input wire logic lr_load_i,
    input wire logic [17:0] lr_data_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [17:0] mem_addr_o,
    output logic [17:0] mem_wdata_o,
    input wire logic [17:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic [17:0] instr_o,
    output logic [3:0] opcode_o,
    output logic [1:0] mode_o,
    output logic mem_ref_o,
    output logic [17:0] ea_o,
    output logic ea_valid_o,
    output logic skip_o,
    output logic [17:0] ip_o,
    output logic [17:0] xr_o,
    output logic [17:0] lr_o,
    output logic busy_o
);
    // ==========================================================
    // decode helpers
    // ==========================================================
    function automatic logic is_mem_ref(input logic [3:0] op);
        is_mem_ref = (op != NONMEM_OP0) && (op != NONMEM_OP1) && (op != NONMEM_OP2);
    endfunction

    function automatic logic is_autoinc(input logic [17:0] addr);
        is_autoinc = addr[`EA_AUTOINC_TAG_HI:`EA_AUTOINC_TAG_LO] == `EA_AUTOINC_TAG;
    endfunction

    ea_pkg::ea_state_e state;
    logic [17:0] ptr;
    logic [3:0] opcode;
    ea_pkg::addr_mode_e mode;
    logic [17:0] page_addr;
    logic [17:0] ip_inc1;
    logic [17:0] ip_inc2;
    logic [17:0] add_a;
    logic [17:0] add_sum;
    logic [17:0] ptr_rd_inc;
    logic [17:0] ind_addr;
    logic [17:0] idx_step;
    logic [17:0] next_xr;
    logic [17:0] next_ea;
    logic ea_fire;
    logic idx_skip_now;
    logic ptr_auto;

    // bit 0 of a word is the vector msb
    // opcode from the four top bits
    assign opcode = instr_o[`EA_OPCODE_HI:`EA_OPCODE_LO];
    // mode field picks the address path
    assign mode = ea_pkg::addr_mode_e'(instr_o[`EA_MODE_HI:`EA_MODE_LO]);
    // page and bank ride with the pointer
    assign page_addr = {ip_o[`EA_PAGE_HI:`EA_PAGE_LO],
                        instr_o[`EA_OPERAND_HI:`EA_OPERAND_LO]};
    assign opcode_o = opcode;
    assign mode_o = instr_o[`EA_MODE_HI:`EA_MODE_LO];
    assign mem_ref_o = is_mem_ref(opcode);
    assign busy_o = (state != ea_pkg::ST_IDLE);
    assign idx_skip_now = (state == ea_pkg::ST_DECODE) && (opcode == IDX_SKIP_OP);
    assign ptr_auto = is_autoinc(page_addr);

    page_counter #(.WORD_W(18), .CNT_W(12)) u_inc1 (
        .value_i(ip_o),
        .next_o(ip_inc1)
    );
    page_counter #(.WORD_W(18), .CNT_W(12)) u_inc2 (
        .value_i(ip_inc1),
        .next_o(ip_inc2)
    );

    assign idx_step = {{(18 - `EA_STEP_W){instr_o[`EA_STEP_HI]}},
                       instr_o[`EA_STEP_HI:0]};
    assign next_xr = xr_o + idx_step;
    assign ptr_rd_inc = mem_rdata_i + 18'h00001;

    // ==========================================================
    // address formation
    // ==========================================================
    always_comb begin
        // block bits from the pointer register
        // low 15 pointer bits, single level
        if (state == ea_pkg::ST_INCWR) begin
            ind_addr = {ip_o[`EA_BLOCK_HI:`EA_BLOCK_LO], ptr[`EA_PTR_HI:`EA_PTR_LO]};
        end else if (ptr_auto) begin
            ind_addr = {ip_o[`EA_BLOCK_HI:`EA_BLOCK_LO], ptr_rd_inc[`EA_PTR_HI:`EA_PTR_LO]};
        end else begin
            ind_addr = {ip_o[`EA_BLOCK_HI:`EA_BLOCK_LO], mem_rdata_i[`EA_PTR_HI:`EA_PTR_LO]};
        end
    end

    assign add_a = (state == ea_pkg::ST_DECODE) ? page_addr : ind_addr;

    // signed index added to page address in decode, else to indirect address
    ea_adder #(.WORD_W(18)) u_add (
        .a_i(add_a),
        .b_i(xr_o),
        .sum_o(add_sum)
    );

    always_comb begin
        next_ea = add_a;
        ea_fire = 1'b0;
        case (state)
            ea_pkg::ST_DECODE: begin
                // direct uses the page address as is
                // indexed resolves in the same cycle
                if (mem_ref_o && !idx_skip_now && !mode[1]) begin
                    ea_fire = 1'b1;
                    next_ea = (mode == ea_pkg::MODE_INDEXED) ? add_sum : page_addr;
                end
            end
            ea_pkg::ST_PTR: begin
                if (mem_ack_i && !ptr_auto) begin
                    ea_fire = 1'b1;
                end
                // index added after the pointer resolves
                next_ea = (mode == ea_pkg::MODE_IND_INDEXED) ? add_sum : ind_addr;
            end
            ea_pkg::ST_INCWR: begin
                if (mem_req_o && mem_ack_i) begin
                    ea_fire = 1'b1;
                end
                next_ea = (mode == ea_pkg::MODE_IND_INDEXED) ? add_sum : ind_addr;
            end
            default: begin
                ea_fire = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // sequencer
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ea_pkg::ST_IDLE;
        end else begin
            case (state)
                ea_pkg::ST_IDLE: begin
                    if (run_i) begin
                        state <= ea_pkg::ST_FETCH;
                    end
                end
                ea_pkg::ST_FETCH: begin
                    if (mem_ack_i) begin
                        state <= ea_pkg::ST_DECODE;
                    end
                end
                ea_pkg::ST_DECODE: begin
                    // indirect modes need the pointer cycle
                    if (mem_ref_o && !idx_skip_now && mode[1]) begin
                        state <= ea_pkg::ST_PTR;
                    end else begin
                        state <= ea_pkg::ST_DONE;
                    end
                end
                ea_pkg::ST_PTR: begin
                    if (mem_ack_i) begin
                        state <= ptr_auto ? ea_pkg::ST_INCWR : ea_pkg::ST_DONE;
                    end
                end
                ea_pkg::ST_INCWR: begin
                    if (mem_req_o && mem_ack_i) begin
                        state <= ea_pkg::ST_DONE;
                    end
                end
                ea_pkg::ST_DONE: begin
                    state <= ea_pkg::ST_IDLE;
                end
                default: begin
                    state <= ea_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // memory cycles
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 18'h00000;
            mem_wdata_o <= 18'h00000;
        end else if (mem_req_o) begin
            if (mem_ack_i) begin
                mem_req_o <= 1'b0;
                mem_we_o <= 1'b0;
            end
        end else begin
            case (state)
                ea_pkg::ST_IDLE: begin
                    if (run_i) begin
                        // only this read yields an instruction
                        mem_req_o <= 1'b1;
                        mem_addr_o <= ip_o;
                    end
                end
                ea_pkg::ST_DECODE: begin
                    if (mem_ref_o && !idx_skip_now && mode[1]) begin
                        mem_req_o <= 1'b1;
                        mem_addr_o <= page_addr;
                    end
                end
                ea_pkg::ST_INCWR: begin
                    // write back before the operand is touched
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_wdata_o <= ptr;
                end
                default: begin
                    mem_req_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // instruction and pointer capture
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_o <= 18'h00000;
        end else if (state == ea_pkg::ST_FETCH && mem_ack_i) begin
            instr_o <= mem_rdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr <= 18'h00000;
        end else if (state == ea_pkg::ST_PTR && mem_ack_i) begin
            ptr <= ptr_auto ? ptr_rd_inc : mem_rdata_i;
        end
    end

    // ==========================================================
    // instruction pointer
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ip_o <= `EA_IP_RESET;
        end else if (ip_load_i && state == ea_pkg::ST_IDLE) begin
            ip_o <= ip_data_i;
        end else if (state == ea_pkg::ST_FETCH && mem_ack_i) begin
            ip_o <= ip_inc1;
        end else if (idx_skip_now && ($signed(next_xr) > $signed(lr_o))) begin
            ip_o <= ip_inc1;
        end else if (ea_fire && opcode == JMP_OP) begin
            case (mode)
                ea_pkg::MODE_DIRECT: ip_o <= next_ea;
                ea_pkg::MODE_INDIRECT: ip_o <= {ip_o[17:15], next_ea[`EA_PTR_HI:0]};
                default: ip_o <= {ip_o[17], next_ea[`EA_JMP_IDX_HI:0]};
            endcase
        end
    end

    // ==========================================================
    // index and limit registers
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xr_o <= `EA_XR_RESET;
        end else if (xr_load_i) begin
            xr_o <= xr_data_i;
        end else if (idx_skip_now) begin
            xr_o <= next_xr;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lr_o <= `EA_LR_RESET;
        end else if (lr_load_i) begin
            lr_o <= lr_data_i;
        end
    end

    // ==========================================================
    // results
    // ==========================================================
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ea_o <= 18'h00000;
            ea_valid_o <= 1'b0;
            skip_o <= 1'b0;
        end else begin
            ea_valid_o <= ea_fire;
            skip_o <= idx_skip_now && ($signed(next_xr) > $signed(lr_o));
            if (ea_fire) begin
                ea_o <= next_ea;
            end
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    ip_page_wrap_a: assert property (
        (state == ea_pkg::ST_FETCH && mem_ack_i && !ip_load_i)
        |=> (ip_o[17:12] == $past(ip_o[17:12]))
            && (ip_o[11:0] == $past(ip_o[11:0]) + 12'h001))
        else $error("pointer increment left its page");

    direct_ea_a: assert property (
        (ea_valid_o && mode == ea_pkg::MODE_DIRECT) |-> ea_o[11:0] == instr_o[11:0])
        else $error("direct address lost operand bits");

    index_no_wait_a: assert property (
        (state == ea_pkg::ST_DECODE && mem_ref_o && !idx_skip_now && !mode[1])
        |=> ea_valid_o && !mem_req_o)
        else $error("indexed address was late");

    indirect_ptr_a: assert property (
        (state == ea_pkg::ST_PTR && mem_ack_i && !ptr_auto && mode == ea_pkg::MODE_INDIRECT)
        |=> ea_valid_o && ea_o[14:0] == $past(mem_rdata_i[14:0]))
        else $error("indirect address wrong");

    autoinc_wb_a: assert property (
        (state == ea_pkg::ST_PTR && mem_ack_i && ptr_auto)
        |-> ##2 (mem_req_o && mem_we_o && !ea_valid_o
                 && mem_wdata_o == $past(mem_rdata_i, 2) + 18'h00001))
        else $error("auto-increment write missing");

    idx_step_add_a: assert property (
        (idx_skip_now && !xr_load_i)
        |=> xr_o == $past(xr_o) + {{10{$past(instr_o[7])}}, $past(instr_o[7:0])})
        else $error("index step wrong");

    idx_skip_a: assert property (
        idx_skip_now |=> skip_o == ($signed(xr_o) > $signed(lr_o)))
        else $error("skip decision wrong");

    jump_ind_a: assert property (
        (ea_valid_o && opcode == JMP_OP && mode == ea_pkg::MODE_INDIRECT)
        |-> ip_o[14:0] == ea_o[14:0] && ip_o[17:15] == $past(ip_o[17:15]))
        else $error("indirect jump loaded wrong bits");

    nonmem_none_a: assert property (
        (state == ea_pkg::ST_DECODE && !mem_ref_o) |=> !ea_valid_o && !mem_req_o)
        else $error("non-memory code produced an address");

    autoinc_c: cover property (
        state == ea_pkg::ST_INCWR && mem_req_o && mem_ack_i);
    skip_c: cover property (skip_o);
    ind_idx_c: cover property (ea_valid_o && mode == ea_pkg::MODE_IND_INDEXED);
    indexed_c: cover property (ea_valid_o && mode == ea_pkg::MODE_INDEXED);
endmodule // effective_address_unit
`default_nettype wire

// [tb/core_memory_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// core memory behind the request and acknowledge handshake
// ==========================================================
module core_memory_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [17:0] mem_addr_i,
    input wire logic [17:0] mem_wdata_i,
    input wire logic [3:0] latency_i,
    output logic mem_ack_o,
    output logic [17:0] mem_rdata_o
);
    logic [17:0] mem [logic [17:0]];
    logic [3:0] wait_cnt;
    int writes = 0;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata_o <= 18'h15555;
        end else begin
            mem_ack_o <= 1'b0;
            // released data lines flip every cycle
            mem_rdata_o <= ~mem_rdata_o;
            if (mem_req_i && !mem_ack_o) begin
                if (wait_cnt == latency_i) begin
                    wait_cnt <= 4'h0;
                    mem_ack_o <= 1'b1;
                    if (mem_we_i) begin
                        mem[mem_addr_i] = mem_wdata_i;
                        writes++;
                    end else begin
                        mem_rdata_o <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : 18'h00000;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule // core_memory_model
`default_nettype wire

// [tb/effective_address_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
end
module effective_address_unit_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic run_i = 1'b0, ip_load_i = 1'b0, xr_load_i = 1'b0, lr_load_i = 1'b0;
    logic [17:0] ip_data_i = 18'h00000, xr_data_i = 18'h00000, lr_data_i = 18'h00000;
    logic mem_req_o, mem_we_o, mem_ack_i, mem_ref_o, ea_valid_o, skip_o, busy_o;
    logic [17:0] mem_addr_o, mem_wdata_o, mem_rdata_i, instr_o, ea_o, ip_o, xr_o, lr_o;
    logic [3:0] opcode_o;
    logic [1:0] mode_o;
    logic [3:0] lat = 4'h0;
    logic [17:0] ea_seen;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    int ea_cnt, skip_cnt, wr0, wr_at_ea, cyc, cyc_d;

    always #4 clk_sys_i = ~clk_sys_i;

    effective_address_unit uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .run_i(run_i),
        .ip_load_i(ip_load_i), .ip_data_i(ip_data_i), .xr_load_i(xr_load_i),
        .xr_data_i(xr_data_i), .lr_load_i(lr_load_i), .lr_data_i(lr_data_i),
        .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
        .instr_o(instr_o), .opcode_o(opcode_o), .mode_o(mode_o), .mem_ref_o(mem_ref_o),
        .ea_o(ea_o), .ea_valid_o(ea_valid_o), .skip_o(skip_o), .ip_o(ip_o), .xr_o(xr_o),
        .lr_o(lr_o), .busy_o(busy_o));

    core_memory_model mem_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .latency_i(lat), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));

    // ==========================================================
    // pulse monitor and cycle ceiling
    // ==========================================================
    always @(posedge clk_sys_i) begin
        cycles++;
        if (ea_valid_o === 1'b1) begin
            ea_cnt++;
            ea_seen = ea_o;
            wr_at_ea = mem_model.writes;
        end
        if (skip_o === 1'b1) begin
            skip_cnt++;
        end
        if (cycles == 4000) begin
            miscompares++;
            end_sim();
        end
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic set_xl(input logic [17:0] xr, input logic [17:0] lr);
        xr_load_i = 1'b1;
        xr_data_i = xr;
        lr_load_i = 1'b1;
        lr_data_i = lr;
        tick();
        xr_load_i = 1'b0;
        lr_load_i = 1'b0;
    endtask

    // one instruction at ip, cycles until idle land in cyc
    task automatic exec(input logic [17:0] ip, input logic [17:0] instr);
        mem_model.mem[ip] = instr;
        ip_load_i = 1'b1;
        ip_data_i = ip;
        tick();
        ip_load_i = 1'b0;
        ea_cnt = 0;
        skip_cnt = 0;
        wr0 = mem_model.writes;
        wr_at_ea = -1;
        run_i = 1'b1;
        tick();
        run_i = 1'b0;
        cyc = 0;
        while (busy_o !== 1'b0 && cyc < 100) begin
            tick();
            cyc++;
        end
        `CHK("idle", 1'b0, busy_o)
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_direct();
        set_xl(18'h00000, 18'h00000);
        exec(18'h05FFF, 18'h04123);
        cyc_d = cyc;
        `CHK("instr", 18'h04123, instr_o)
        `CHK("opcode", 4'h1, opcode_o)
        `CHK("mode", 2'h0, mode_o)
        `CHK("memref", 1'b1, mem_ref_o)
        `CHK("ea direct", 18'h05123, ea_seen)
        `CHK("ea pulses", 1, ea_cnt)
        `CHK("ip wrap", 18'h05000, ip_o)
        $display("test direct done");
    endtask

    task automatic t_indexed();
        set_xl(18'h3FFFE, 18'h00000);
        exec(18'h01000, 18'h09001);
        `CHK("mode", 2'h1, mode_o)
        `CHK("ea indexed", 18'h00FFF, ea_seen)
        `CHK("ip inc", 18'h01001, ip_o)
        `CHK("indexed time", cyc_d, cyc)
        $display("test indexed done");
    endtask

    task automatic t_indirect();
        set_xl(18'h00010, 18'h00000);
        mem_model.mem[18'h21050] = 18'h3ABCD;
        exec(18'h21000, 18'h0E050);
        `CHK("ea indirect", 18'h22BCD, ea_seen)
        `CHK("second cycle", 1'b1, cyc > cyc_d)
        `CHK("no write", wr0, mem_model.writes)
        exec(18'h21000, 18'h0F050);
        `CHK("mode", 2'h3, mode_o)
        `CHK("ea ind idx", 18'h22BDD, ea_seen)
        $display("test indirect done");
    endtask

    task automatic t_autoinc();
        set_xl(18'h00000, 18'h00000);
        lat = 4'h2;
        mem_model.mem[18'h0000F] = 18'h01FFF;
        mem_model.mem[18'h00010] = 18'h00777;
        exec(18'h00100, 18'h0600F);
        `CHK("incremented", 18'h02000, mem_model.mem[18'h0000F])
        `CHK("ea autoinc", 18'h02000, ea_seen)
        `CHK("write first", wr0 + 1, wr_at_ea)
        exec(18'h00100, 18'h06010);
        `CHK("ea outside", 18'h00777, ea_seen)
        `CHK("no write", wr0, mem_model.writes)
        exec(18'h00100, 18'h0400F);
        `CHK("ea plain", 18'h0000F, ea_seen)
        `CHK("untouched", 18'h02000, mem_model.mem[18'h0000F])
        lat = 4'h0;
        $display("test autoinc done");
    endtask

    task automatic t_index_skip();
        set_xl(18'h00005, 18'h00006);
        `CHK("limit", 18'h00006, lr_o)
        exec(18'h00200, 18'h38002);
        `CHK("xr add", 18'h00007, xr_o)
        `CHK("skip", 1, skip_cnt)
        `CHK("ip skip", 18'h00202, ip_o)
        `CHK("no ea", 0, ea_cnt)
        exec(18'h00300, 18'h380FF);
        `CHK("xr sub", 18'h00006, xr_o)
        `CHK("equal no skip", 0, skip_cnt)
        `CHK("ip", 18'h00301, ip_o)
        set_xl(18'h3FFFE, 18'h00001);
        exec(18'h00400, 18'h38001);
        `CHK("xr neg", 18'h3FFFF, xr_o)
        `CHK("signed no skip", 0, skip_cnt)
        $display("test index skip done");
    endtask

    task automatic t_jump();
        set_xl(18'h00000, 18'h00000);
        exec(18'h21000, 18'h36050);
        `CHK("jump indirect", 18'h22BCD, ip_o)
        set_xl(18'h20000, 18'h00000);
        exec(18'h01000, 18'h35005);
        `CHK("ea jump", 18'h21005, ea_seen)
        `CHK("jump indexed", 18'h01005, ip_o)
        exec(18'h00700, 18'h34123);
        `CHK("jump direct", 18'h00123, ip_o)
        $display("test jump done");
    endtask

    task automatic t_nonmem();
        exec(18'h00500, 18'h30000);
        `CHK("memref C", 1'b0, mem_ref_o)
        `CHK("no ea C", 0, ea_cnt)
        `CHK("ip", 18'h00501, ip_o)
        exec(18'h00600, 18'h3C000);
        `CHK("opcode F", 4'hF, opcode_o)
        `CHK("memref F", 1'b0, mem_ref_o)
        $display("test nonmem done");
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        `CHK("reset ip", 18'h00000, ip_o)
        `CHK("reset req", 1'b0, mem_req_o)
        rst_b_i = 1'b1;
        tick();
        t_direct();
        t_indexed();
        t_indirect();
        t_autoinc();
        t_index_skip();
        t_jump();
        t_nonmem();
        end_sim();
    end
endmodule // effective_address_unit_tb
`default_nettype wire
